// [core/ple_engine.sv]
// postfix logic equation engine: parameter store, editor, checker and evaluator
// assumes a periodic tick slower than one full pass and operands sampled by the caller
// Functional notes
// - stop at the first end marker; later entries are skipped
// - positive one-shot pulses on a false to true input change
// - negative one-shot pulses on a true to false input change
// - dual one-shot pulses on either edge
// - one-shot output is true for exactly one pass
// - thirty-two one-shots, each with its own previous input
// - inverter complements the single preceding value
// - xor is true when exactly one of two preceding values is true
// - latch holds state, set by set input, reset wins
// - latch reset input is newest value, set input the one before
// - thirty-two timers started by the preceding value, output as operand
// - assignment copies the preceding value into one of 64 virtual outputs
// - a virtual output assignment ends the current equation
// - duplicate timer or assignment use raises a syntax error
// - entries run in order; earlier outputs feed later equations
// - latches clear when power returns
// - any new setting recompiles and clears all latches
// - the store supports insert and delete with shifting
`timescale 1ns/1ps
module ple_engine (
	input wire logic clock, // 50 MHz clock
	input wire logic rst, // async reset, active high
	input wire ple_pkg::ple_edit_t edit, // editor command
	input wire logic edit_valid, // editor command strobe
	output logic edit_ready, // editor may be accepted (idle)
	input wire logic tick, // periodic evaluation tick
	input wire logic [255:0] operands, // external operand states, same clock
	input wire logic [31:0] timer_out, // timer outputs from the timer block
	output logic [31:0] timer_start_q, // timer start inputs
	output logic [63:0] vout_q, // virtual output bits
	output logic [8:0] list_len_q, // stored entry count
	output logic syntax_err_q, // duplicate timer or assignment
	output logic busy, // pass or check in progress
	output logic pass_done_q, // one-cycle pulse at end of pass
	output logic overrun_q // tick arrived while still busy
);
	ple_pkg::ple_entry_t mem_q [0:ple_pkg::LIST_DEPTH-1];
	ple_pkg::ple_state_t state_q;
	logic [8:0] pc_q;
	logic [31:0] stack_q;
	logic [5:0] sp_q;
	logic [31:0] latch_q;
	logic [31:0] tmr_seen_q;
	logic [63:0] vo_seen_q;
	logic clr_q;
	ple_pkg::ple_entry_t cur;
	logic at_end;
	logic top0;
	logic top1;
	logic gate_res;
	logic [31:0] shot_pulse;
	logic result;
	logic push;
	logic [5:0] pops;
	logic eval_step;
	logic edit_go;

	assign cur = mem_q[pc_q];
	assign top0 = stack_q[0];
	assign top1 = stack_q[1];
	assign busy = (state_q != ple_pkg::PLE_ST_IDLE);
	assign edit_ready = ~busy;
	assign edit_go = edit_valid & ~busy;
	assign eval_step = (state_q == ple_pkg::PLE_ST_EVAL) & ~at_end;
	assign at_end = (pc_q >= list_len_q) | (cur.op == ple_pkg::PLE_OP_END);

	// parameter store; edits only while idle so a pass never sees a half-shifted list
	always_ff @(posedge clock) begin
		// a full store holds one entry less than the array, so the 9-bit count never wraps
		if (edit_go && edit.cmd == ple_pkg::PLE_ED_INSERT &&
			list_len_q < 9'(ple_pkg::LIST_DEPTH - 1)) begin
			for (int i = ple_pkg::LIST_DEPTH - 1; i > 0; i--) begin
				if (9'(i) > edit.pos)
					mem_q[i] <= mem_q[i-1];
			end
			mem_q[edit.pos] <= edit.entry;
		end else if (edit_go && edit.cmd == ple_pkg::PLE_ED_DELETE && edit.pos < list_len_q) begin
			for (int i = 0; i < ple_pkg::LIST_DEPTH - 1; i++) begin
				if (9'(i) >= edit.pos)
					mem_q[i] <= mem_q[i+1];
			end
		end
	end

	// entry count follows the edits
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			list_len_q <= ple_pkg::LEN_RESET;
		else if (edit_go && edit.cmd == ple_pkg::PLE_ED_INSERT &&
			list_len_q < 9'(ple_pkg::LIST_DEPTH - 1))
			list_len_q <= list_len_q + 9'h001;
		else if (edit_go && edit.cmd == ple_pkg::PLE_ED_DELETE && edit.pos < list_len_q)
			list_len_q <= list_len_q - 9'h001;
		else if (edit_go && edit.cmd == ple_pkg::PLE_ED_CLEAR)
			list_len_q <= ple_pkg::LEN_RESET;
	end

	// any accepted edit triggers a recompile that clears state
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			clr_q <= 1'b0;
		else
			clr_q <= edit_go && edit.cmd != ple_pkg::PLE_ED_NONE;
	end

	// one-shots, one instance each with its own memory
	for (genvar g = 0; g < ple_pkg::NUM_SHOTS; g++) begin : g_shot
		ple_shot u_shot (
			.clock(clock),
			.rst(rst),
			.clr(clr_q),
			.use_en(eval_step && cur.arg[4:0] == 5'(g) && (cur.op == ple_pkg::PLE_OP_SHOT_POS ||
				cur.op == ple_pkg::PLE_OP_SHOT_NEG || cur.op == ple_pkg::PLE_OP_SHOT_DUAL)),
			.din(top0),
			.rise_en(cur.op == ple_pkg::PLE_OP_SHOT_POS || cur.op == ple_pkg::PLE_OP_SHOT_DUAL),
			.fall_en(cur.op == ple_pkg::PLE_OP_SHOT_NEG || cur.op == ple_pkg::PLE_OP_SHOT_DUAL),
			.pulse(shot_pulse[g])
		);
	end

	// gate count is clamped so a bad argument never reaches past the window
	ple_gate u_gate (
		.win(stack_q[15:0]),
		.cnt((cur.arg[4:0] < 5'(ple_pkg::GATE_MIN)) ? 5'(ple_pkg::GATE_MIN) :
			(cur.arg[4:0] > 5'(ple_pkg::GATE_MAX)) ? 5'(ple_pkg::GATE_MAX) : cur.arg[4:0]),
		.op(cur.op),
		.result(gate_res)
	);

	// result of the current entry and its stack effect
	always_comb begin
		result = 1'b0;
		push = 1'b1;
		pops = 6'h00;
		unique case (cur.op)
			ple_pkg::PLE_OP_OPERAND: result = operands[cur.arg];
			ple_pkg::PLE_OP_SHOT_POS, ple_pkg::PLE_OP_SHOT_NEG, ple_pkg::PLE_OP_SHOT_DUAL: begin
				result = shot_pulse[cur.arg[4:0]];
				pops = 6'h01;
			end
			ple_pkg::PLE_OP_NOT: begin
				result = ~top0;
				pops = 6'h01;
			end
			ple_pkg::PLE_OP_OR, ple_pkg::PLE_OP_AND, ple_pkg::PLE_OP_NOR, ple_pkg::PLE_OP_NAND: begin
				result = gate_res;
				pops = (cur.arg[4:0] < 5'(ple_pkg::GATE_MIN)) ? 6'(ple_pkg::GATE_MIN) :
					(cur.arg[4:0] > 5'(ple_pkg::GATE_MAX)) ? 6'(ple_pkg::GATE_MAX) : {1'b0, cur.arg[4:0]};
			end
			ple_pkg::PLE_OP_XOR: begin
				result = top0 ^ top1;
				pops = 6'h02;
			end
			ple_pkg::PLE_OP_LATCH: begin
				result = ~top0 & (top1 | latch_q[cur.arg[4:0]]);
				pops = 6'h02;
			end
			ple_pkg::PLE_OP_TIMER: begin
				result = timer_out[cur.arg[4:0]];
				pops = 6'h01;
			end
			ple_pkg::PLE_OP_VOUT: begin
				push = 1'b0;
				pops = 6'h01;
			end
			default: push = 1'b0;
		endcase
	end

	// sequencer: check duplicates after each edit, then evaluate per tick
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= ple_pkg::PLE_ST_IDLE;
			pc_q <= 9'h000;
		end else begin
			unique case (state_q)
				ple_pkg::PLE_ST_IDLE: begin
					pc_q <= 9'h000;
					if (clr_q)
						state_q <= ple_pkg::PLE_ST_CHECK;
					else if (tick && !edit_go)
						state_q <= ple_pkg::PLE_ST_EVAL; // an edit in the same cycle wins
				end
				ple_pkg::PLE_ST_CHECK: begin
					if (at_end)
						state_q <= ple_pkg::PLE_ST_IDLE;
					pc_q <= pc_q + 9'h001;
				end
				ple_pkg::PLE_ST_EVAL: begin
					if (at_end)
						state_q <= ple_pkg::PLE_ST_IDLE;
					pc_q <= pc_q + 9'h001;
				end
				default: state_q <= ple_pkg::PLE_ST_IDLE;
			endcase
		end
	end

	// operand stack as a shift register, newest value in bit 0
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stack_q <= 32'h00000000;
			sp_q <= 6'h00;
		end else if (state_q == ple_pkg::PLE_ST_IDLE) begin
			stack_q <= 32'h00000000;
			sp_q <= 6'h00;
		end else if (eval_step) begin
			if (push)
				stack_q <= {stack_q >> pops} << 1 | {31'h00000000, result};
			else
				stack_q <= stack_q >> pops;
			sp_q <= sp_q - pops + {5'h00, push};
		end
	end

	// latch memories; volatile, cleared by reset and recompile
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			latch_q <= 32'h00000000;
		else if (clr_q)
			latch_q <= 32'h00000000;
		else if (eval_step && cur.op == ple_pkg::PLE_OP_LATCH)
			latch_q[cur.arg[4:0]] <= result;
	end

	// timer starts and virtual outputs; earlier assignments visible as later operands via caller
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			timer_start_q <= 32'h00000000;
			vout_q <= 64'h0000000000000000;
		end else if (clr_q) begin
			timer_start_q <= 32'h00000000;
			vout_q <= 64'h0000000000000000;
		end else if (eval_step) begin
			if (cur.op == ple_pkg::PLE_OP_TIMER)
				timer_start_q[cur.arg[4:0]] <= top0;
			if (cur.op == ple_pkg::PLE_OP_VOUT)
				vout_q[cur.arg[5:0]] <= top0;
		end
	end

	// duplicate detection during the check walk; error holds until next recompile
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tmr_seen_q <= 32'h00000000;
			vo_seen_q <= 64'h0000000000000000;
			syntax_err_q <= 1'b0;
		end else if (clr_q) begin
			tmr_seen_q <= 32'h00000000;
			vo_seen_q <= 64'h0000000000000000;
			syntax_err_q <= 1'b0;
		end else if (state_q == ple_pkg::PLE_ST_CHECK && !at_end) begin
			if (cur.op == ple_pkg::PLE_OP_TIMER) begin
				tmr_seen_q[cur.arg[4:0]] <= 1'b1;
				if (tmr_seen_q[cur.arg[4:0]])
					syntax_err_q <= 1'b1;
			end
			if (cur.op == ple_pkg::PLE_OP_VOUT) begin
				vo_seen_q[cur.arg[5:0]] <= 1'b1;
				if (vo_seen_q[cur.arg[5:0]])
					syntax_err_q <= 1'b1;
			end
		end
	end

	// pass status: done pulse and overrun when a tick finds us busy
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pass_done_q <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			pass_done_q <= (state_q == ple_pkg::PLE_ST_EVAL) && at_end;
			// a late tick beats a clear that lands in the same cycle
			if (tick && busy)
				overrun_q <= 1'b1;
			else if (clr_q)
				overrun_q <= 1'b0;
		end
	end
endmodule

// [shared/ple_pkg.sv]
// package for the postfix logic equation engine: entry encoding, sizes, states
// assumes one 50 MHz clock and a single engine instance per program store
package ple_pkg;
	localparam int unsigned LIST_DEPTH = 512;
	localparam int unsigned LIST_AW = 9;
	localparam int unsigned STACK_DEPTH = 32;
	localparam int unsigned STACK_AW = 5;
	localparam int unsigned NUM_OPERANDS = 256;
	localparam int unsigned NUM_SHOTS = 32;
	localparam int unsigned NUM_TIMERS = 32;
	localparam int unsigned NUM_VOUT = 64;
	localparam int unsigned GATE_MIN = 2;
	localparam int unsigned GATE_MAX = 16;
	localparam logic [8:0] LEN_RESET = 9'h000;

	// opcode of one parameter entry
	typedef enum logic [3:0] {
		PLE_OP_END = 4'h0,
		PLE_OP_OPERAND = 4'h1,
		PLE_OP_SHOT_POS = 4'h2,
		PLE_OP_SHOT_NEG = 4'h3,
		PLE_OP_SHOT_DUAL = 4'h4,
		PLE_OP_NOT = 4'h5,
		PLE_OP_OR = 4'h6,
		PLE_OP_AND = 4'h7,
		PLE_OP_NOR = 4'h8,
		PLE_OP_NAND = 4'h9,
		PLE_OP_XOR = 4'ha,
		PLE_OP_LATCH = 4'hb,
		PLE_OP_TIMER = 4'hc,
		PLE_OP_VOUT = 4'hd
	} ple_op_t;

	// one parameter: opcode plus argument (operand index, gate count, shot/timer/vout index)
	typedef struct packed {
		ple_op_t op;
		logic [7:0] arg;
	} ple_entry_t;

	// editor command from the configuration side
	typedef enum logic [1:0] {
		PLE_ED_NONE = 2'h0,
		PLE_ED_INSERT = 2'h1,
		PLE_ED_DELETE = 2'h2,
		PLE_ED_CLEAR = 2'h3
	} ple_ed_t;

	typedef struct packed {
		ple_ed_t cmd;
		logic [8:0] pos;
		ple_entry_t entry;
	} ple_edit_t;

	typedef enum logic [3:0] {
		PLE_ST_IDLE = 4'b0001,
		PLE_ST_CHECK = 4'b0010,
		PLE_ST_EVAL = 4'b0100,
		PLE_ST_GATE = 4'b1000
	} ple_state_t;
endpackage

// [core/ple_shot.sv]
// one edge one-shot: remembers its input from the previous pass
// assumes use_en is set once per evaluation pass, at the step that evaluates this shot
`timescale 1ns/1ps
module ple_shot (
	input wire logic clock, // 50 MHz clock
	input wire logic rst, // async reset, active high
	input wire logic clr, // recompile clear
	input wire logic use_en, // this shot is evaluated in the current step
	input wire logic din, // operand value
	input wire logic rise_en, // respond to rising edge
	input wire logic fall_en, // respond to falling edge
	output logic pulse // edge detected this pass
);
	logic prev_q;

	// previous input kept only when the shot is evaluated, so the edge spans passes
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			prev_q <= 1'b0;
		else if (clr)
			prev_q <= 1'b0;
		else if (use_en)
			prev_q <= din;
	end

	// pulse is true for exactly the pass in which the edge is seen
	assign pulse = (rise_en & din & ~prev_q) | (fall_en & ~din & prev_q);
endmodule

// [core/ple_gate.sv]
// n-input gate over the top of the operand stack window
// assumes the caller passes the top 16 stack bits and a valid count 2..16
`timescale 1ns/1ps
module ple_gate (
	input wire logic [15:0] win, // stack window, bit 0 is the newest value
	input wire logic [4:0] cnt, // number of inputs
	input wire ple_pkg::ple_op_t op, // gate kind
	output logic result // gate output
);
	logic [15:0] mask;
	logic any_one;
	logic all_one;

	// mask off stack bits beyond the gate's own inputs
	always_comb begin
		mask = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			if (5'(i) < cnt)
				mask[i] = 1'b1;
		end
		any_one = |(win & mask);
		all_one = &(win | ~mask);
		unique case (op)
			ple_pkg::PLE_OP_OR: result = any_one;
			ple_pkg::PLE_OP_AND: result = all_one;
			ple_pkg::PLE_OP_NOR: result = ~any_one;
			ple_pkg::PLE_OP_NAND: result = ~all_one;
			default: result = 1'b0;
		endcase
	end
endmodule

// [dv/ple_engine_sva.sv]
// checker for the equation engine top ports
// assumes one clock domain and an async active-high reset
`timescale 1ns/1ps
module ple_engine_sva (
	input wire logic clock, // clock
	input wire logic rst, // reset
	input wire ple_pkg::ple_edit_t edit, // editor command
	input wire logic edit_valid, // editor strobe
	input wire logic edit_ready, // editor ready
	input wire logic tick, // pass tick
	input wire logic [255:0] operands, // operand states
	input wire logic [31:0] timer_out, // timer outputs
	input wire logic [31:0] timer_start_q, // timer starts
	input wire logic [63:0] vout_q, // virtual outputs
	input wire logic [8:0] list_len_q, // entry count
	input wire logic syntax_err_q, // syntax error
	input wire logic busy, // busy
	input wire logic pass_done_q, // pass end pulse
	input wire logic overrun_q // overrun flag
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic take;
	logic take_q;
	logic go;
	// an accepted command, and a tick that is not hidden by a pending recompile
	assign take = edit_valid && edit_ready && edit.cmd != ple_pkg::PLE_ED_NONE;
	assign go = tick && !busy && !edit_valid && !take_q;
	// remembers a command of the last cycle, whose recompile hides a tick
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			take_q <= 1'b0;
		end else begin
			take_q <= take;
		end
	end
	edit_busy_a: assert property (take |-> ##2 busy)
		else $error("no check walk after edit");
	ins_len_a: assert property (take && edit.cmd == ple_pkg::PLE_ED_INSERT
		&& list_len_q < 9'h1ff |=> list_len_q == $past(list_len_q) + 9'h001)
		else $error("insert count wrong");
	del_len_a: assert property (take && edit.cmd == ple_pkg::PLE_ED_DELETE
		&& edit.pos < list_len_q |=> list_len_q == $past(list_len_q) - 9'h001)
		else $error("delete count wrong");
	clr_len_a: assert property (take && edit.cmd == ple_pkg::PLE_ED_CLEAR |=> list_len_q == 9'h000)
		else $error("clear left entries");
	vout_wipe_a: assert property (take |-> ##2 vout_q == 64'h0)
		else $error("outputs kept over recompile");
	pass_start_a: assert property (go |=> busy)
		else $error("tick did not start pass");
	pass_end_a: assert property (go |-> ##[2:514] pass_done_q)
		else $error("pass did not end");
	done_pulse_a: assert property (pass_done_q |-> !busy ##1 !pass_done_q)
		else $error("pass end not one pulse");
	over_run_a: assert property (tick && busy |=> overrun_q)
		else $error("overrun not flagged");
	err_keep_a: assert property (syntax_err_q && !take && !take_q |=> syntax_err_q)
		else $error("syntax error dropped");
	ready_idle_a: assert property (busy |-> !edit_ready)
		else $error("ready while busy");
endmodule

bind ple_engine ple_engine_sva chk_u (.clock(clock), .rst(rst), .edit(edit),
	.edit_valid(edit_valid), .edit_ready(edit_ready), .tick(tick), .operands(operands),
	.timer_out(timer_out), .timer_start_q(timer_start_q), .vout_q(vout_q),
	.list_len_q(list_len_q), .syntax_err_q(syntax_err_q), .busy(busy),
	.pass_done_q(pass_done_q), .overrun_q(overrun_q));

// [dv/ple_cfg_model.sv]
// configuration side model: hands parameter entries to the editor port
// assumes the caller supplies entries in list order
`timescale 1ns/1ps
module ple_cfg_model (
	input wire logic clock, // clock
	input wire logic edit_ready, // editor ready
	output ple_pkg::ple_edit_t edit, // editor command
	output logic edit_valid // editor strobe
);
	initial begin
		edit = '0;
		edit_valid = 1'b0;
	end
	// hold the command until ready is seen, then scramble it so stale data is not reused
	task automatic send(input ple_pkg::ple_ed_t cmd, input logic [8:0] pos,
		input ple_pkg::ple_entry_t ent);
		int n;
		n = 0;
		@(posedge clock);
		edit <= '{cmd: cmd, pos: pos, entry: ent};
		edit_valid <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (edit_ready !== 1'b1 && n < 64);
		edit_valid <= 1'b0;
		edit <= ple_pkg::ple_edit_t'(~edit);
		repeat (2) @(posedge clock);
		n = 0;
		while (edit_ready !== 1'b1 && n < 600) begin
			@(posedge clock);
			n++;
		end
	endtask
endmodule

// [dv/tb_top.sv]
// testbench for the equation engine: builds programs and runs passes
// assumes the configuration model drives the editor port
`timescale 1ns/1ps
module tb_top;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic tick = 1'b0;
	logic [255:0] operands = '0;
	logic [31:0] timer_out = '0;
	ple_pkg::ple_edit_t edit;
	logic edit_valid;
	logic edit_ready;
	logic [31:0] timer_start_q;
	logic [63:0] vout_q;
	logic [8:0] list_len_q;
	logic syntax_err_q;
	logic busy;
	logic pass_done_q;
	logic overrun_q;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_len = 0;
	ple_engine dut_u (.clock(clock), .rst(rst), .edit(edit), .edit_valid(edit_valid),
		.edit_ready(edit_ready), .tick(tick), .operands(operands), .timer_out(timer_out),
		.timer_start_q(timer_start_q), .vout_q(vout_q), .list_len_q(list_len_q),
		.syntax_err_q(syntax_err_q), .busy(busy), .pass_done_q(pass_done_q),
		.overrun_q(overrun_q));
	ple_cfg_model cfg_u (.clock(clock), .edit_ready(edit_ready), .edit(edit),
		.edit_valid(edit_valid));
	// 50 MHz clock
	always #10 clock = ~clock;
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// hang guard, generous over the few thousand cycles the tests need
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic chk(input logic got, input logic exp, input string m);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic add(input ple_pkg::ple_op_t op, input logic [7:0] arg);
		cfg_u.send(ple_pkg::PLE_ED_INSERT, 9'(n_len), '{op: op, arg: arg});
		n_len++;
	endtask
	task automatic wipe();
		cfg_u.send(ple_pkg::PLE_ED_CLEAR, 9'h000, '0);
		n_len = 0;
	endtask
	// one pass with fresh operands; the engine is idle on entry
	task automatic pass(input logic [15:0] v);
		int n;
		@(posedge clock);
		operands <= 256'(v);
		@(posedge clock);
		tick <= 1'b1;
		@(posedge clock);
		tick <= 1'b0;
		n = 0;
		while (pass_done_q !== 1'b1 && n < 600) begin
			@(posedge clock);
			n++;
		end
		chk(n < 600, 1'b1, "pass end missing");
		@(posedge clock);
	endtask
	task automatic t_gates();
		ple_pkg::ple_op_t g[5] = '{ple_pkg::PLE_OP_OR, ple_pkg::PLE_OP_AND, ple_pkg::PLE_OP_NOR,
			ple_pkg::PLE_OP_NAND, ple_pkg::PLE_OP_XOR};
		logic a;
		logic b;
		for (int k = 0; k < 5; k++) begin
			add(ple_pkg::PLE_OP_OPERAND, 8'h00);
			add(ple_pkg::PLE_OP_OPERAND, 8'h01);
			add(g[k], 8'h02);
			add(ple_pkg::PLE_OP_VOUT, 8'(k));
		end
		add(ple_pkg::PLE_OP_OPERAND, 8'h00);
		add(ple_pkg::PLE_OP_NOT, 8'h00);
		add(ple_pkg::PLE_OP_VOUT, 8'h05);
		for (int k = 0; k < 16; k++) add(ple_pkg::PLE_OP_OPERAND, 8'(k));
		add(ple_pkg::PLE_OP_AND, 8'h10);
		add(ple_pkg::PLE_OP_VOUT, 8'h07);
		add(ple_pkg::PLE_OP_END, 8'h00);
		add(ple_pkg::PLE_OP_OPERAND, 8'h00);
		add(ple_pkg::PLE_OP_VOUT, 8'h06);
		chk(list_len_q === 9'(n_len), 1'b1, "entry count");
		for (int v = 0; v < 4; v++) begin
			pass(16'(v));
			a = v[0];
			b = v[1];
			chk(vout_q[0], a | b, "or");
			chk(vout_q[1], a & b, "and");
			chk(vout_q[2], !(a | b), "nor");
			chk(vout_q[3], !(a & b), "nand");
			chk(vout_q[4], a ^ b, "xor");
			chk(vout_q[5], !a, "not");
			chk(vout_q[6], 1'b0, "entry after end ran");
		end
		pass(16'hffff);
		chk(vout_q[7], 1'b1, "and16 all ones");
		pass(16'h7fff);
		chk(vout_q[7], 1'b0, "and16 one low");
		$display("test gates done");
	endtask
	task automatic t_latch();
		logic [1:0] sr[6] = '{2'h1, 2'h0, 2'h3, 2'h1, 2'h2, 2'h1};
		logic q;
		q = 1'b0;
		wipe();
		add(ple_pkg::PLE_OP_OPERAND, 8'h00);
		add(ple_pkg::PLE_OP_OPERAND, 8'h01);
		add(ple_pkg::PLE_OP_LATCH, 8'h00);
		add(ple_pkg::PLE_OP_VOUT, 8'h00);
		add(ple_pkg::PLE_OP_END, 8'h00);
		for (int i = 0; i < 6; i++) begin
			pass(16'(sr[i]));
			q = sr[i][1] ? 1'b0 : (sr[i][0] ? 1'b1 : q);
			chk(vout_q[0], q, "latch state");
		end
		add(ple_pkg::PLE_OP_END, 8'h00);
		chk(vout_q[0], 1'b0, "output kept over edit");
		pass(16'h0000);
		chk(vout_q[0], 1'b0, "latch kept over edit");
		$display("test latch done");
	endtask
	task automatic t_shots();
		logic [5:0] x = 6'b100110;
		logic p;
		p = 1'b0;
		wipe();
		add(ple_pkg::PLE_OP_OPERAND, 8'h00);
		add(ple_pkg::PLE_OP_SHOT_POS, 8'h00);
		add(ple_pkg::PLE_OP_VOUT, 8'h00);
		add(ple_pkg::PLE_OP_OPERAND, 8'h00);
		add(ple_pkg::PLE_OP_SHOT_NEG, 8'h01);
		add(ple_pkg::PLE_OP_VOUT, 8'h01);
		add(ple_pkg::PLE_OP_OPERAND, 8'h00);
		add(ple_pkg::PLE_OP_SHOT_DUAL, 8'h02);
		add(ple_pkg::PLE_OP_VOUT, 8'h02);
		for (int i = 0; i < 6; i++) begin
			pass(16'(x[i]));
			chk(vout_q[0], x[i] & !p, "rising shot");
			chk(vout_q[1], !x[i] & p, "falling shot");
			chk(vout_q[2], x[i] ^ p, "dual shot");
			p = x[i];
		end
		$display("test shots done");
	endtask
	task automatic t_timer();
		ple_pkg::ple_entry_t dup[2] = '{'{ple_pkg::PLE_OP_VOUT, 8'h00},
			'{ple_pkg::PLE_OP_TIMER, 8'h03}};
		wipe();
		add(ple_pkg::PLE_OP_OPERAND, 8'h00);
		add(ple_pkg::PLE_OP_TIMER, 8'h03);
		add(ple_pkg::PLE_OP_VOUT, 8'h00);
		timer_out <= 32'h00000008;
		pass(16'h0001);
		chk(timer_start_q[3], 1'b1, "timer start");
		chk(vout_q[0], 1'b1, "timer output");
		timer_out <= 32'h00000000;
		pass(16'h0000);
		chk(timer_start_q[3], 1'b0, "timer stop");
		chk(vout_q[0], 1'b0, "timer output low");
		for (int i = 0; i < 2; i++) begin
			cfg_u.send(ple_pkg::PLE_ED_INSERT, 9'h003, dup[i]);
			chk(syntax_err_q, 1'b1, "duplicate not flagged");
			cfg_u.send(ple_pkg::PLE_ED_DELETE, 9'h003, '0);
			chk(syntax_err_q, 1'b0, "error after delete");
			chk(list_len_q === 9'h003, 1'b1, "count after delete");
		end
		@(posedge clock);
		tick <= 1'b1;
		repeat (2) @(posedge clock);
		tick <= 1'b0;
		repeat (10) @(posedge clock);
		chk(overrun_q, 1'b1, "overrun");
		$display("test timer done");
	endtask
	initial begin
		repeat (16) @(posedge clock);
		rst <= 1'b0;
		t_gates();
		t_latch();
		t_shots();
		t_timer();
		complete_run();
	end
endmodule
